// ===== hw/orsq_sequencer.sv
// Purpose: Output regulation sequencer for a buck-boost power stage
// Assumes: Sense inputs come from the analogue side, asynchronous
// Notes:   Long timers are parameters so simulation can shorten them
`timescale 1ns/1ps
module orsq_sequencer
#(
  parameter int DLY1_CYCLES   = orsq_pkg::DLY1_CYC,
  parameter int DLY2_CYCLES   = orsq_pkg::DLY2_CYC,
  parameter int DLY3_CYCLES   = orsq_pkg::DLY3_CYC,
  parameter int HICCUP_CYCLES = orsq_pkg::HICCUP_CYC
)
(
  input  wire logic       ref_clk,
  input  wire logic       reset,
  input  wire logic [7:0] regAddr,
  input  wire logic [7:0] regWrData,
  input  wire logic       regWrEn,
  input  wire logic       regRdEn,
  output logic      [7:0] regRdData,
  input  wire logic       convEnable,
  input  wire logic [7:0] vinSense,
  input  wire logic [9:0] voutSense,
  input  wire logic       outputLimitSense,
  input  wire logic       lightLoadSense,
  output logic            outputEnable,
  output logic      [9:0] targetCode,
  output logic      [6:0] effectiveScalePct,
  output logic            dischargeSinkEnable,
  output logic            currentRegulationFlag,
  output logic      [2:0] stateCode
);

  // ==========================================================
  // Helpers
  function automatic logic [6:0] applyScale(input logic [6:0] v);
    if (v == 7'h00)
      return orsq_pkg::SCALE_MIN;
    else if (v > orsq_pkg::SCALE_MAX)
      return orsq_pkg::SCALE_MAX;
    else
      return v;
  endfunction

  // ==========================================================
  // Input synchronisers
  logic [7:0] vinS1, vinS;
  logic [9:0] voutS1, voutS;
  logic       limS1, limS, llS1, llS, onS1, onS;

  always_ff @(posedge ref_clk)
  begin
    vinS1  <= vinSense;
    vinS   <= vinS1;
    voutS1 <= voutSense;
    voutS  <= voutS1;
    limS1  <= outputLimitSense;
    limS   <= limS1;
    llS1   <= lightLoadSense;
    llS    <= llS1;
    onS1   <= convEnable;
    onS    <= onS1;
  end

  // ==========================================================
  // Register file
  logic [9:0] setpoint_r, setpoint_nxt;
  logic [6:0] scale_r, scale_nxt;
  logic [7:0] start_r, start_nxt, slew_r, slew_nxt;
  logic [7:0] margin_r, margin_nxt, base_r, base_nxt;

  always_comb
  begin
    setpoint_nxt = setpoint_r;
    scale_nxt    = scale_r;
    start_nxt    = start_r;
    slew_nxt     = slew_r;
    margin_nxt   = margin_r;
    base_nxt     = base_r;
    if (regWrEn)
    begin
      unique case (regAddr)
        orsq_pkg::ADDR_VLO:    setpoint_nxt[7:0] = regWrData;
        orsq_pkg::ADDR_VHI:    setpoint_nxt[9:8] = regWrData[1:0];
        orsq_pkg::ADDR_SCALE:  scale_nxt = regWrData[6:0];
        orsq_pkg::ADDR_START:  start_nxt = regWrData;
        orsq_pkg::ADDR_SLEW:   slew_nxt = regWrData;
        orsq_pkg::ADDR_MARGIN: margin_nxt = regWrData;
        orsq_pkg::ADDR_BASE:   base_nxt = regWrData;
        default:               setpoint_nxt = setpoint_r;
      endcase
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      setpoint_r <= orsq_pkg::VOUT_RST;
      scale_r    <= orsq_pkg::SCALE_RST;
      start_r    <= orsq_pkg::BYTE_RST;
      slew_r     <= orsq_pkg::BYTE_RST;
      margin_r   <= orsq_pkg::BYTE_RST;
      base_r     <= orsq_pkg::BYTE_RST;
    end
    else
    begin
      setpoint_r <= setpoint_nxt;
      scale_r    <= scale_nxt;
      start_r    <= start_nxt;
      slew_r     <= slew_nxt;
      margin_r   <= margin_nxt;
      base_r     <= base_nxt;
    end
  end

  logic [1:0] slewSel, ssSel, dlySel;
  logic       sinkEn;
  assign slewSel = slew_r[orsq_pkg::SLEW_LSB +: 2];
  assign sinkEn  = slew_r[orsq_pkg::SINK_BIT];
  assign ssSel   = start_r[orsq_pkg::SS_LSB +: 2];
  assign dlySel  = start_r[orsq_pkg::DLY_LSB +: 2];

  // Threshold clamps at zero so a large margin never wraps to a high trip
  logic underVolt;
  assign underVolt = ({1'b0, vinS} + {1'b0, margin_r}) < {1'b0, base_r};

  // ==========================================================
  // Rate dividers
  logic [11:0] slewPeriod, ssPeriod;
  logic [25:0] dlyTarget;
  logic        slewTick, ssTick;
  localparam orsq_pkg::orsq_state_t ORSQ_OFF     = orsq_pkg::ORSQ_OFF,
                                    ORSQ_RESTART = orsq_pkg::ORSQ_RESTART,
                                    ORSQ_SOFT    = orsq_pkg::ORSQ_SOFT,
                                    ORSQ_REG     = orsq_pkg::ORSQ_REG,
                                    ORSQ_HICCUP  = orsq_pkg::ORSQ_HICCUP,
                                    ORSQ_LLOFF   = orsq_pkg::ORSQ_LLOFF;
  orsq_pkg::orsq_state_t state_r, state_nxt;
  logic [9:0]  ramp_r, ramp_nxt;

  always_comb
  begin
    unique case (slewSel)
      2'h0: slewPeriod = orsq_pkg::SLEW0_CYC;
      2'h1: slewPeriod = orsq_pkg::SLEW1_CYC;
      2'h2: slewPeriod = orsq_pkg::SLEW2_CYC;
      2'h3: slewPeriod = orsq_pkg::SLEW3_CYC;
    endcase
    unique case (ssSel)
      2'h0: ssPeriod = orsq_pkg::SS0_CYC;
      2'h1: ssPeriod = orsq_pkg::SS1_CYC;
      2'h2: ssPeriod = orsq_pkg::SS2_CYC;
      2'h3: ssPeriod = orsq_pkg::SS3_CYC;
    endcase
    unique case (dlySel)
      2'h0: dlyTarget = 26'h0000000;
      2'h1: dlyTarget = 26'(DLY1_CYCLES);
      2'h2: dlyTarget = 26'(DLY2_CYCLES);
      2'h3: dlyTarget = 26'(DLY3_CYCLES);
    endcase
  end

  orsq_tick slewDiv
  (
    .ref_clk (ref_clk),
    .reset   (reset),
    .clear   (state_r != ORSQ_REG || setpoint_r <= ramp_r),
    .period  (slewPeriod),
    .tick    (slewTick)
  );

  orsq_tick ssDiv
  (
    .ref_clk (ref_clk),
    .reset   (reset),
    .clear   (state_r != ORSQ_SOFT),
    .period  (ssPeriod),
    .tick    (ssTick)
  );

  // ==========================================================
  // Operating state machine
  logic [25:0] timer_r, timer_nxt;
  logic [9:0]  frac_r, frac_nxt;

  always_comb
  begin
    state_nxt = state_r;
    timer_nxt = timer_r;
    frac_nxt  = frac_r;
    if (!onS)
    begin
      state_nxt = ORSQ_OFF;
      timer_nxt = 26'h0000000;
      frac_nxt  = 10'h000;
    end
    else if (underVolt && state_r != ORSQ_LLOFF)
    begin
      state_nxt = ORSQ_RESTART;
      timer_nxt = 26'h0000000;
      frac_nxt  = 10'h000;
    end
    else
    begin
      unique case (state_r)
        ORSQ_OFF:
          state_nxt = ORSQ_RESTART;
        ORSQ_RESTART:
          if (timer_r >= dlyTarget)
          begin
            state_nxt = ORSQ_SOFT;
            timer_nxt = 26'h0000000;
            frac_nxt  = 10'h000;
          end
          else
            timer_nxt = timer_r + 26'h0000001;
        ORSQ_SOFT:
          if (ssTick)
          begin
            if (frac_r == orsq_pkg::FRAC_FULL)
              state_nxt = ORSQ_REG;
            else
              frac_nxt = frac_r + 10'h001;
          end
        ORSQ_REG:
          if (voutS < orsq_pkg::FAULT_CODE)
          begin
            state_nxt = ORSQ_HICCUP;
            timer_nxt = 26'h0000000;
          end
          else if (llS)
            state_nxt = ORSQ_LLOFF;
        ORSQ_HICCUP:
          if (timer_r >= 26'(HICCUP_CYCLES - 1))
          begin
            state_nxt = ORSQ_RESTART;
            timer_nxt = 26'h0000000;
          end
          else
            timer_nxt = timer_r + 26'h0000001;
        ORSQ_LLOFF:
          state_nxt = ORSQ_LLOFF;
      endcase
    end
  end

  // ==========================================================
  // Target ramp, sink and outputs
  logic [20:0] ssProd;
  logic        sink_r, sink_nxt;
  logic        cc_nxt, oe_nxt;
  logic [2:0]  code_nxt;

  // Soft start scales the code by elapsed fraction, so time is code-free
  assign ssProd = 21'(setpoint_r) * 21'({1'b0, frac_r} + 11'h001);

  always_comb
  begin
    ramp_nxt = 10'h000;
    sink_nxt = 1'b0;
    if (state_nxt == ORSQ_SOFT)
      ramp_nxt = ssProd[19:10];
    else if (state_nxt == ORSQ_REG)
    begin
      ramp_nxt = (state_r == ORSQ_REG) ? ramp_r : setpoint_r;
      if (state_r == ORSQ_REG && setpoint_r > ramp_r && slewTick)
        ramp_nxt = ramp_r + 10'h001;
      else if (state_r == ORSQ_REG && setpoint_r < ramp_r)
        ramp_nxt = setpoint_r;
      // Set wins over release when a new downward step lands
      if (state_r == ORSQ_REG && setpoint_r < ramp_r && sinkEn)
        sink_nxt = 1'b1;
      else if (sink_r && voutS > ramp_r)
        sink_nxt = 1'b1;
    end
    oe_nxt = state_nxt == ORSQ_SOFT || state_nxt == ORSQ_REG;
    cc_nxt = state_nxt == ORSQ_REG && limS;
    unique case (state_nxt)
      ORSQ_SOFT:   code_nxt = orsq_pkg::ST_SOFT;
      ORSQ_REG:    code_nxt = orsq_pkg::ST_REG;
      ORSQ_HICCUP: code_nxt = orsq_pkg::ST_HICCUP;
      ORSQ_LLOFF:  code_nxt = orsq_pkg::ST_LLOFF;
      default:     code_nxt = orsq_pkg::ST_RST;
    endcase
  end

  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      state_r               <= ORSQ_OFF;
      timer_r               <= 26'h0000000;
      frac_r                <= 10'h000;
      ramp_r                <= 10'h000;
      sink_r                <= 1'b0;
      outputEnable          <= 1'b0;
      currentRegulationFlag <= 1'b0;
      stateCode             <= orsq_pkg::ST_RST;
      effectiveScalePct     <= orsq_pkg::SCALE_RST;
    end
    else
    begin
      state_r               <= state_nxt;
      timer_r               <= timer_nxt;
      frac_r                <= frac_nxt;
      ramp_r                <= ramp_nxt;
      sink_r                <= sink_nxt;
      outputEnable          <= oe_nxt;
      currentRegulationFlag <= cc_nxt;
      stateCode             <= code_nxt;
      effectiveScalePct     <= applyScale(scale_r);
    end
  end

  assign targetCode          = ramp_r;
  assign dischargeSinkEnable = sink_r;

  // ==========================================================
  // Register read port
  always_ff @(posedge ref_clk)
  begin
    if (reset)
      regRdData <= 8'h00;
    else if (regRdEn)
    begin
      unique case (regAddr)
        orsq_pkg::ADDR_VLO:    regRdData <= setpoint_r[7:0];
        orsq_pkg::ADDR_VHI:    regRdData <= {6'h00, setpoint_r[9:8]};
        orsq_pkg::ADDR_SCALE:  regRdData <= {1'b0, scale_r};
        orsq_pkg::ADDR_START:  regRdData <= start_r;
        orsq_pkg::ADDR_SLEW:   regRdData <= slew_r;
        orsq_pkg::ADDR_MARGIN: regRdData <= margin_r;
        orsq_pkg::ADDR_BASE:   regRdData <= base_r;
        orsq_pkg::ADDR_STATUS:
          regRdData <= {4'h0, currentRegulationFlag, stateCode};
        default:               regRdData <= 8'h00;
      endcase
    end
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);

  chk_fault_hiccup: assert property (
    (state_r == ORSQ_REG && onS && !underVolt
     && voutS < orsq_pkg::FAULT_CODE) |=> state_r == ORSQ_HICCUP ##1 !outputEnable)
    else $error("Output fault did not enter hiccup");
  chk_hiccup_exit: assert property (
    (state_r == ORSQ_HICCUP && timer_r == 26'(HICCUP_CYCLES - 1) && onS
     && !underVolt) |=> state_r == ORSQ_RESTART)
    else $error("Hiccup did not end in restart");
  chk_uv_restart: assert property (
    (onS && underVolt && state_r != ORSQ_LLOFF)
    |=> state_r == ORSQ_RESTART && !outputEnable)
    else $error("Undervoltage did not force restart");
  chk_scale_zero: assert property (
    scale_r == 7'h00 |=> effectiveScalePct == orsq_pkg::SCALE_MIN)
    else $error("Zero scale not applied as one percent");
  chk_scale_high: assert property (
    scale_r > orsq_pkg::SCALE_MAX |=> effectiveScalePct == orsq_pkg::SCALE_MAX)
    else $error("High scale not clamped");
  chk_ramp_step: assert property (
    (state_r == ORSQ_REG) ##1 (state_r == ORSQ_REG && ramp_r > $past(ramp_r))
    |-> ramp_r == $past(ramp_r) + 10'h001)
    else $error("Upward ramp stepped by more than one code");
  chk_sink_on: assert property (
    (state_nxt == ORSQ_REG && state_r == ORSQ_REG && sinkEn
     && setpoint_r < ramp_r) |=> dischargeSinkEnable)
    else $error("Sink not enabled on downward step");
  chk_zero_delay: assert property (
    (state_r == ORSQ_RESTART && dlySel == 2'h0 && onS && !underVolt)
    |=> state_r == ORSQ_SOFT && stateCode == orsq_pkg::ST_SOFT)
    else $error("Zero start delay not immediate");
  chk_cc_flag: assert property (
    (state_nxt == ORSQ_REG && limS) |=> currentRegulationFlag)
    else $error("Current regulation flag not set");

endmodule

// ===== hw/orsq_pkg.sv
// Purpose: Constants for the output regulation sequencer
// Assumes: 10 MHz ref_clk; register port at the device register offsets
// Notes:   Timing counts are derived from times in their own units
//
// Behaviour
// - Output target is 2.96 V plus 20 mV per step of a 10-bit code.
// - A 2-bit selector picks target ramp rate from 1 V/ms to 0.1 V/ms.
// - Upward target changes ramp at the selected rate, never step.
// - Input below base minus margin turns output off and restarts.
// - Downward target with sink enabled turns on sink until regulation.
// - Valid start conditions run a selectable 0 ms to 1 s start delay.
// - Soft start follows the delay; its duration ignores the voltage code.
// - Current limit is hardware maximum times a 7-bit percent code.
// - Current scale field stores any 7-bit value written.
// - Scale of zero reads back zero but applies one percent.
// - Scale above 100 reads back as written but applies 100 percent.
// - Current above scaled limit moves regulation to constant current.
// - Read-only flag: 0 constant voltage, 1 constant current.
// - Output below 3 V enters hiccup with output off for 3 s.
// - After hiccup go to restart; cycle while fault stays, until disabled.
// - 3-bit state code: restart, soft start, regulate, hiccup, light load.
package orsq_pkg;

  // ==========================================================
  // Register offsets
  localparam logic [7:0] ADDR_START  = 8'h0E;
  localparam logic [7:0] ADDR_MARGIN = 8'h0F;
  localparam logic [7:0] ADDR_SLEW   = 8'h10;
  localparam logic [7:0] ADDR_VLO    = 8'h13;
  localparam logic [7:0] ADDR_VHI    = 8'h14;
  localparam logic [7:0] ADDR_SCALE  = 8'h17;
  localparam logic [7:0] ADDR_BASE   = 8'h1A;
  localparam logic [7:0] ADDR_STATUS = 8'h20;

  // ==========================================================
  // Field positions
  localparam int SLEW_LSB   = 0;
  localparam int SINK_BIT   = 2;
  localparam int SS_LSB     = 0;
  localparam int DLY_LSB    = 2;
  localparam int CC_BIT     = 3;

  // ==========================================================
  // Reset values, clamps and thresholds
  localparam logic [9:0] VOUT_RST   = 10'h066;
  localparam logic [6:0] SCALE_RST  = 7'h64;
  localparam logic [7:0] BYTE_RST   = 8'h00;
  localparam logic [6:0] SCALE_MIN  = 7'h01;
  localparam logic [6:0] SCALE_MAX  = 7'h64;
  localparam logic [9:0] FAULT_CODE = 10'h002;
  localparam logic [9:0] FRAC_FULL  = 10'h3FF;

  // ==========================================================
  // Status codes
  localparam logic [2:0] ST_RST    = 3'h0;
  localparam logic [2:0] ST_SOFT   = 3'h1;
  localparam logic [2:0] ST_REG    = 3'h2;
  localparam logic [2:0] ST_HICCUP = 3'h3;
  localparam logic [2:0] ST_LLOFF  = 3'h4;

  // ==========================================================
  // Timing
  localparam int CLK_HZ    = 10_000_000;
  localparam int CYC_PER_US = CLK_HZ / 1_000_000;
  localparam int CYC_PER_MS = CLK_HZ / 1000;
  // Time per 20 mV step for 1, 0.5, 0.2 and 0.1 V/ms
  localparam int SLEW0_US = 20;
  localparam int SLEW1_US = 40;
  localparam int SLEW2_US = 100;
  localparam int SLEW3_US = 200;
  localparam logic [11:0] SLEW0_CYC = 12'(SLEW0_US * CYC_PER_US);
  localparam logic [11:0] SLEW1_CYC = 12'(SLEW1_US * CYC_PER_US);
  localparam logic [11:0] SLEW2_CYC = 12'(SLEW2_US * CYC_PER_US);
  localparam logic [11:0] SLEW3_CYC = 12'(SLEW3_US * CYC_PER_US);
  // Soft start durations, spread over 1024 fraction steps
  localparam int SS0_MS = 1;
  localparam int SS1_MS = 2;
  localparam int SS2_MS = 4;
  localparam int SS3_MS = 8;
  localparam logic [11:0] SS0_CYC = 12'((SS0_MS * CYC_PER_MS + 1023) / 1024);
  localparam logic [11:0] SS1_CYC = 12'((SS1_MS * CYC_PER_MS + 1023) / 1024);
  localparam logic [11:0] SS2_CYC = 12'((SS2_MS * CYC_PER_MS + 1023) / 1024);
  localparam logic [11:0] SS3_CYC = 12'((SS3_MS * CYC_PER_MS + 1023) / 1024);
  // Start delay choices and hiccup time
  localparam int DLY1_MS   = 10;
  localparam int DLY2_MS   = 100;
  localparam int DLY3_MS   = 1000;
  localparam int HICCUP_MS = 3000;
  localparam int DLY1_CYC   = DLY1_MS * CYC_PER_MS;
  localparam int DLY2_CYC   = DLY2_MS * CYC_PER_MS;
  localparam int DLY3_CYC   = DLY3_MS * CYC_PER_MS;
  localparam int HICCUP_CYC = HICCUP_MS * CYC_PER_MS;

  typedef enum logic [2:0] {
    ORSQ_OFF, ORSQ_RESTART, ORSQ_SOFT, ORSQ_REG, ORSQ_HICCUP, ORSQ_LLOFF
  } orsq_state_t;

endpackage

// ===== hw/orsq_tick.sv
// Purpose: Programmable period divider giving one-cycle enable pulses
// Assumes: period of at least one cycle
// Notes:   Clear restarts a full period so the first tick is never early
`timescale 1ns/1ps
module orsq_tick
(
  input  wire logic        ref_clk,
  input  wire logic        reset,
  input  wire logic        clear,
  input  wire logic [11:0] period,
  output logic             tick
);

  logic [11:0] count_r;
  logic [11:0] count_nxt;
  logic        tick_nxt;

  // ==========================================================
  // Down counter
  always_comb
  begin
    count_nxt = count_r - 12'h001;
    tick_nxt  = 1'b0;
    if (clear)
    begin
      count_nxt = period - 12'h001;
    end
    else if (count_r == 12'h000)
    begin
      count_nxt = period - 12'h001;
      tick_nxt  = 1'b1;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      count_r <= 12'h000;
      tick    <= 1'b0;
    end
    else
    begin
      count_r <= count_nxt;
      tick    <= tick_nxt;
    end
  end

endmodule

// ===== dv/orsq_stage_model.sv
// Purpose: Power stage and load stand-in for the sequencer
// Assumes: Output moves one code per clock toward the reference
// Notes:   A short pulls the output to zero, as a hard fault would
`timescale 1ns/1ps
module orsq_stage_model
(
  input  wire logic       ref_clk,
  input  wire logic       outputEnable,
  input  wire logic [9:0] targetCode,
  input  wire logic       shortOut,
  input  wire logic       overload,
  output logic      [9:0] voutSense,
  output logic            outputLimitSense
);
  // ==========================================================
  // Output voltage
  // Slow follower so the discharge sink is seen on for some cycles
  initial voutSense = 10'h000;
  always @(posedge ref_clk)
    if (shortOut || !outputEnable)
      voutSense <= 10'h000;
    else if (voutSense < targetCode)
      voutSense <= voutSense + 10'h001;
    else if (voutSense > targetCode)
      voutSense <= voutSense - 10'h001;
  // Overload only shows while the stage switches
  assign outputLimitSense = overload && outputEnable;
endmodule

// ===== dv/test_output_regulation_sequencer.sv
// Purpose: Self-checking bench for the output regulation sequencer
// Assumes: Timers shortened through parameters
// Notes:   Register shadow and clamps are modelled with integers
`timescale 1ns/1ps
module test_output_regulation_sequencer;
  localparam int DLY1 = 20;
  localparam int HIC  = 100;
  logic       ref_clk    = 1'b0;
  logic       reset      = 1'b1;
  logic [7:0] regAddr    = 8'h00;
  logic [7:0] regWrData  = 8'h00;
  logic       regWrEn    = 1'b0;
  logic       regRdEn    = 1'b0;
  logic       convEnable = 1'b0;
  logic [7:0] vinSense   = 8'hC8;
  logic       lightLoad  = 1'b0;
  logic       shortOut   = 1'b0;
  logic       overload   = 1'b0;
  logic [7:0] regRdData;
  logic [9:0] voutSense;
  logic       outLim;
  logic       outEn;
  logic       sinkEn;
  logic       ccFlag;
  logic [9:0] targetCode;
  logic [6:0] scalePct;
  logic [2:0] stateCode;
  logic [7:0] rdv;
  logic [7:0] sv [8] = '{8'h00, 8'h01, 8'h32, 8'h64, 8'h65, 8'h7F,
                         8'h00, 8'h00};
  int         mdl [int];
  int         n;
  int         sp [4]         = '{200, 400, 1000, 2000};
  int         dl [4]         = '{0, DLY1, 40, 80};
  int         miscompares    = 0;
  int         samplesChecked = 0;

  always #50 ref_clk = ~ref_clk;

  orsq_sequencer #(.DLY1_CYCLES(DLY1), .DLY2_CYCLES(40),
    .DLY3_CYCLES(80), .HICCUP_CYCLES(HIC)) i_dut
  (.ref_clk(ref_clk), .reset(reset), .regAddr(regAddr),
   .regWrData(regWrData), .regWrEn(regWrEn), .regRdEn(regRdEn),
   .regRdData(regRdData), .convEnable(convEnable),
   .vinSense(vinSense), .voutSense(voutSense),
   .outputLimitSense(outLim), .lightLoadSense(lightLoad),
   .outputEnable(outEn), .targetCode(targetCode),
   .effectiveScalePct(scalePct), .dischargeSinkEnable(sinkEn),
   .currentRegulationFlag(ccFlag), .stateCode(stateCode));

  orsq_stage_model i_stage
  (.ref_clk(ref_clk), .outputEnable(outEn), .targetCode(targetCode),
   .shortOut(shortOut), .overload(overload), .voutSense(voutSense),
   .outputLimitSense(outLim));

  // ==========================================================
  // Compare, bus and wait tasks
  task automatic chk_val(string nm, int exp, logic [9:0] got);
    samplesChecked++;
    if (got !== 10'(exp))
    begin
      miscompares++;
      $display("FAIL %s exp %0h got %0h", nm, exp, got);
    end
  endtask

  task automatic chk_reg(logic [7:0] a, int exp, logic [7:0] got);
    samplesChecked++;
    if (got !== 8'(exp))
    begin
      miscompares++;
      $display("FAIL reg %h exp %0h got %0h", a, exp, got);
    end
  endtask

  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(posedge ref_clk);
    regAddr <= a;
    regWrData <= d;
    regWrEn <= 1'b1;
    @(posedge ref_clk);
    regWrEn <= 1'b0;
    if (mdl.exists(a))
      mdl[a] = d;
  endtask

  // Read data lands the edge after the read is taken
  task automatic rd(logic [7:0] a, int exp);
    @(posedge ref_clk);
    regAddr <= a;
    regRdEn <= 1'b1;
    @(posedge ref_clk);
    regRdEn <= 1'b0;
    @(negedge ref_clk);
    chk_reg(a, exp, regRdData);
  endtask

  task automatic wait_st(logic [2:0] s, int lim);
    n = 0;
    while (stateCode !== s && n < lim)
    begin
      @(negedge ref_clk);
      n++;
    end
    chk_val("stateCode", s, {7'h00, stateCode});
  endtask

  function automatic int scl(int v);
    return (v == 0) ? 1 : ((v > 100) ? 100 : v);
  endfunction

  task automatic wrap_up();
    $display("checked %0d mismatched %0d", samplesChecked, miscompares);
    if (miscompares == 0 && samplesChecked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // ==========================================================
  // Watchdog sized for nine soft starts; the test runs four
  initial
  begin
    repeat (95000) @(posedge ref_clk);
    miscompares++;
    wrap_up();
  end

  // ==========================================================
  // Main sequence
  initial
  begin
    void'($urandom(32'hd554eec5));
    mdl = '{8'h0E:0, 8'h0F:0, 8'h10:0, 8'h13:8'h66, 8'h14:0,
            8'h17:8'h64, 8'h1A:0};
    sv[6] = 8'($urandom_range(127));
    sv[7] = 8'($urandom_range(127));
    repeat (20) @(posedge ref_clk);
    reset <= 1'b0;
    @(negedge ref_clk);
    chk_val("scalePct", 100, {3'h0, scalePct});
    foreach (mdl[a])
      rd(8'(a), mdl[a]);
    rd(8'h55, 0);
    foreach (sv[i])
    begin
      wr(8'h17, sv[i]);
      rd(8'h17, sv[i]);
      chk_val("scalePct", scl(sv[i]), {3'h0, scalePct});
    end
    wr(8'h20, 8'hFF);
    rd(8'h20, 0);
    @(posedge ref_clk);
    convEnable <= 1'b1;
    wait_st(3'h1, 12);
    chk_val("fastStart", 1, {9'h0, n <= 8});
    chk_val("outEn", 1, {9'h0, outEn});
    wait_st(3'h2, 11000);
    chk_val("targetCode", 10'h066, targetCode);
    rd(8'h20, 8'h02);
    wr(8'h10, 8'h04);
    wr(8'h13, 8'h69);
    n = 0;
    while (targetCode !== 10'h069 && n < 1000)
    begin
      @(negedge ref_clk);
      n++;
    end
    chk_val("rampTime", 1, {9'h0, n >= 400 && n <= 610});
    wr(8'h13, 8'h5F);
    repeat (3) @(negedge ref_clk);
    chk_val("targetCode", 10'h05F, targetCode);
    chk_val("sinkOn", 1, {9'h0, sinkEn});
    n = 0;
    while (sinkEn !== 1'b0 && n < 40)
    begin
      @(negedge ref_clk);
      n++;
    end
    chk_val("sinkOff", 1, {9'h0, n >= 5 && n < 40});
    for (int k = 1; k < 4; k++)
    begin
      wr(8'h10, 8'(k));
      wr(8'h13, 8'(8'h5F + k));
      n = 0;
      while (targetCode !== 10'(8'h5F + k) && n < 2100)
      begin
        @(negedge ref_clk);
        n++;
      end
      chk_val("slewTime", 1, {9'h0, n >= sp[k] && n <= sp[k] + 10});
    end
    @(posedge ref_clk);
    overload <= 1'b1;
    repeat (5) @(negedge ref_clk);
    chk_val("ccFlag", 1, {9'h0, ccFlag});
    rd(8'h20, 8'h0A);
    @(posedge ref_clk);
    overload <= 1'b0;
    repeat (5) @(negedge ref_clk);
    chk_val("ccFlag", 0, {9'h0, ccFlag});
    @(posedge ref_clk);
    shortOut <= 1'b1;
    wait_st(3'h3, 10);
    chk_val("outEn", 0, {9'h0, outEn});
    wait_st(3'h0, HIC + 5);
    chk_val("hiccupTime", 1, {9'h0, n >= HIC - 2});
    wait_st(3'h3, 12000);
    @(posedge ref_clk);
    shortOut <= 1'b0;
    wait_st(3'h2, 11000 + HIC);
    wr(8'h1A, 8'h64);
    wr(8'h0F, 8'h0A);
    @(posedge ref_clk);
    vinSense <= 8'h50;
    wait_st(3'h0, 10);
    chk_val("outEn", 0, {9'h0, outEn});
    @(posedge ref_clk);
    vinSense <= 8'hC8;
    wait_st(3'h2, 11000);
    @(posedge ref_clk);
    lightLoad <= 1'b1;
    wait_st(3'h4, 10);
    @(posedge ref_clk);
    lightLoad <= 1'b0;
    convEnable <= 1'b0;
    wait_st(3'h0, 10);
    rd(8'h20, 0);
    for (int k = 1; k < 4; k++)
    begin
      wr(8'h0E, 8'(k * 4));
      @(posedge ref_clk);
      convEnable <= 1'b1;
      wait_st(3'h1, 120);
      chk_val("delay", 1, {9'h0, n >= dl[k] && n <= dl[k] + 8});
      @(posedge ref_clk);
      convEnable <= 1'b0;
      wait_st(3'h0, 10);
    end
    wrap_up();
  end
endmodule
